// ===== common/irqcfg_pkg.sv
// irqcfg_pkg: constants and types for the interrupt output config block
// assumes a 50 MHz system clock and a 32-bit axi4-lite register bus
//
// How it works
// RULE1: 8-bit interval in 10 us steps, resets zero
// RULE2: writing zero interval stops hold-off, releases pending
// RULE3: new non-zero interval governs later interrupts
// RULE4: wake request bypasses the hold-off interval
// RULE5: restart bit clears counter, starts new interval
// RULE6: read-only flag shows hold-off interval active
// RULE7: read-only master bit shows combined request line
// RULE8: output enable gates pin, off at reset
// RULE9: output enable never touches source status
// RULE10: pin de-assertion starts interval; expiry releases requests
// RULE11: polarity bit selects low or high active in push-pull; open-drain is always active low
// RULE12: buffer bit selects open-drain or push-pull
package irqcfg_pkg;
	// register byte offsets
	localparam logic [7:0] CFG_OFFS = 8'h54;
	localparam logic [7:0] EVT_STS_OFFS = 8'h60;
	localparam logic [7:0] EVT_MSK_OFFS = 8'h64;
	// config register field positions
	localparam int INTV_LSB = 24;
	localparam int RESTART_BIT = 14;
	localparam int ACTIVE_BIT = 13;
	localparam int MASTER_BIT = 12;
	localparam int EN_BIT = 8;
	localparam int POL_BIT = 4;
	localparam int TYPE_BIT = 0;
	// event status bit positions
	localparam int EVT_EXPIRE = 0;
	localparam int EVT_ASSERT = 1;
	localparam int EVT_W = 2;
	// reset values
	localparam logic [7:0] INTV_RST = 8'h00;
	localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
	// timing: one interval step in ns, clock period in ns
	localparam int STEP_NS = 10000;
	localparam int CLK_NS = 20;
	localparam int STEP_CYC = STEP_NS / CLK_NS;
	localparam logic [8:0] STEP_LAST = 9'(STEP_CYC - 1);
	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// software configuration fields
	typedef struct packed {
		logic [7:0] interval;
		logic en;
		logic pol;
		logic btype;
	} irqcfg_cfg_t;
	localparam irqcfg_cfg_t CFG_RST = '{INTV_RST, 1'b0, 1'b0, 1'b0};
	// drive of the interrupt pin
	typedef struct packed {
		logic level;
		logic oe;
	} irqcfg_pin_t;
endpackage : irqcfg_pkg

// ===== hw/irqcfg_top.sv
// irqcfg_top: combines requests, applies hold-off, drives the irq pin
// assumes sources arrive synchronous, already enabled, active high
`timescale 1ns/10ps
`default_nettype none
module irqcfg_top #(
	parameter int NUM_SRC = 8
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// interrupt sources
	input wire logic [NUM_SRC-1:0] src_req_i,
	input wire logic wake_event_request_i,
	// interrupt pin toward host cpu
	output logic irq_pin_o,
	output logic irq_pin_oe_o,
	// block event interrupt
	output logic blk_irq_o,
	// axi4-lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import irqcfg_pkg::*;

	////////////////////////////////////////////////////////////////////
	// state
	irqcfg_cfg_t cfg_ff, nxt_cfg; // software config
	logic active_ff, nxt_active; // hold-off running
	logic [8:0] pre_ff, nxt_pre; // 10 us prescaler
	logic [7:0] step_ff, nxt_step; // elapsed steps
	logic asrt_ff, nxt_asrt; // logical pin assertion
	irqcfg_pin_t pin_ff, nxt_pin; // physical pin drive
	logic [EVT_W-1:0] evt_sts_ff, nxt_evt_sts; // sticky events
	logic [EVT_W-1:0] evt_msk_ff, nxt_evt_msk; // event mask
	logic blk_irq_ff, nxt_blk_irq; // block interrupt
	logic awr_ff, nxt_awr; // aw/w ready pulse
	logic bv_ff, nxt_bv; // write response valid
	logic [1:0] bresp_ff, nxt_bresp; // write response code
	logic arr_ff, nxt_arr; // ar ready pulse
	logic rv_ff, nxt_rv; // read data valid
	logic [1:0] rresp_ff, nxt_rresp; // read response code
	logic [31:0] rdata_ff, nxt_rdata; // read data

	// combinational helpers
	logic master; // combined request line
	logic wr_go; // write handshake this edge
	logic rd_go; // read handshake this edge
	logic zero_wr; // interval written as zero
	logic restart_wr; // restart bit written as one
	logic tick; // one 10 us step elapsed
	logic expire; // hold-off reached its end
	logic [EVT_W-1:0] evt_set; // events raised this cycle

	////////////////////////////////////////////////////////////////////
	// bus decode
	assign wr_go = awr_ff & s_axi_awvalid & s_axi_wvalid;
	assign rd_go = arr_ff & s_axi_arvalid;
	assign zero_wr = wr_go && s_axi_awaddr == CFG_OFFS && s_axi_wstrb[3]
		&& s_axi_wdata[INTV_LSB +: 8] == 8'h00;
	assign restart_wr = wr_go && s_axi_awaddr == CFG_OFFS
		&& s_axi_wstrb[1] && s_axi_wdata[RESTART_BIT];
	// sources keep reporting whatever the enable says
	assign master = (|src_req_i) | wake_event_request_i; // RULE7 RULE9
	assign tick = active_ff && pre_ff == STEP_LAST;
	assign expire = tick && (9'(step_ff) + 9'h001) >= 9'(cfg_ff.interval);

	////////////////////////////////////////////////////////////////////
	// next-state logic for config, hold-off, pin and bus
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_active = active_ff;
		nxt_pre = pre_ff;
		nxt_step = step_ff;
		nxt_evt_msk = evt_msk_ff;
		nxt_awr = 1'b0;
		nxt_bv = bv_ff;
		nxt_bresp = bresp_ff;
		nxt_arr = 1'b0;
		nxt_rv = rv_ff;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		evt_set = '0;
		// hold-off prescaler and step counter
		if (active_ff) begin
			nxt_pre = tick ? 9'h000 : pre_ff + 9'h001;
			if (tick) begin
				nxt_step = step_ff + 8'h01;
			end
		end
		// release held requests at the end of the interval
		if (expire) begin
			nxt_active = 1'b0; // RULE10
			evt_set[EVT_EXPIRE] = 1'b1;
		end
		// pin assertion: wake never waits, others wait out hold-off
		nxt_asrt = cfg_ff.en // RULE8
			& (wake_event_request_i // RULE4
			| ((|src_req_i) & ~active_ff)); // RULE6
		// falling assertion opens a new interval
		if (asrt_ff && !nxt_asrt && cfg_ff.interval != 8'h00) begin
			nxt_active = 1'b1; // RULE10 RULE3
			nxt_pre = 9'h000;
			nxt_step = 8'h00;
		end
		if (nxt_asrt && !asrt_ff) begin
			evt_set[EVT_ASSERT] = 1'b1;
		end
		// open-drain is always active low; push-pull follows polarity
		if (!cfg_ff.btype) begin
			nxt_pin = '{1'b0, nxt_asrt}; // RULE12
		end else begin
			nxt_pin = '{~(nxt_asrt ^ cfg_ff.pol), 1'b1}; // RULE11
		end
		// accept address and data together, one write at a time
		if (s_axi_awvalid && s_axi_wvalid && !awr_ff && !bv_ff) begin
			nxt_awr = 1'b1;
		end
		if (s_axi_bready && bv_ff) begin
			nxt_bv = 1'b0;
		end
		if (wr_go) begin
			nxt_bv = 1'b1;
			nxt_bresp = RESP_OKAY;
			case (s_axi_awaddr)
				CFG_OFFS: begin
					if (s_axi_wstrb[3]) begin
						nxt_cfg.interval = s_axi_wdata[INTV_LSB +: 8]; // RULE1
					end
					if (s_axi_wstrb[1]) begin
						nxt_cfg.en = s_axi_wdata[EN_BIT]; // RULE8
					end
					if (s_axi_wstrb[0]) begin
						nxt_cfg.pol = s_axi_wdata[POL_BIT];
						nxt_cfg.btype = s_axi_wdata[TYPE_BIT];
					end
				end
				EVT_STS_OFFS: begin
					// read-only, write ignored
				end
				EVT_MSK_OFFS: begin
					if (s_axi_wstrb[0]) begin
						nxt_evt_msk = s_axi_wdata[EVT_W-1:0];
					end
				end
				default: begin
					nxt_bresp = RESP_SLVERR;
				end
			endcase
		end
		// restart wins over a running interval, zero write wins over all
		if (restart_wr) begin
			nxt_active = 1'b1; // RULE5
			nxt_pre = 9'h000;
			nxt_step = 8'h00;
		end
		if (zero_wr) begin
			nxt_active = 1'b0; // RULE2
			nxt_pre = 9'h000;
			nxt_step = 8'h00;
		end
		// one read at a time
		if (s_axi_arvalid && !arr_ff && !rv_ff) begin
			nxt_arr = 1'b1;
		end
		if (s_axi_rready && rv_ff) begin
			nxt_rv = 1'b0;
		end
		nxt_evt_sts = evt_sts_ff;
		if (rd_go) begin
			nxt_rv = 1'b1;
			nxt_rresp = RESP_OKAY;
			nxt_rdata = 32'h0000_0000;
			case (s_axi_araddr)
				CFG_OFFS: begin
					nxt_rdata[INTV_LSB +: 8] = cfg_ff.interval;
					nxt_rdata[ACTIVE_BIT] = active_ff; // RULE6
					nxt_rdata[MASTER_BIT] = master; // RULE7
					nxt_rdata[EN_BIT] = cfg_ff.en;
					nxt_rdata[POL_BIT] = cfg_ff.pol;
					nxt_rdata[TYPE_BIT] = cfg_ff.btype;
				end
				EVT_STS_OFFS: begin
					nxt_rdata[EVT_W-1:0] = evt_sts_ff;
					nxt_evt_sts = '0; // cleared by the read
				end
				EVT_MSK_OFFS: begin
					nxt_rdata[EVT_W-1:0] = evt_msk_ff;
				end
				default: begin
					nxt_rresp = RESP_SLVERR;
				end
			endcase
		end
		// a new event beats the read that clears it
		nxt_evt_sts = nxt_evt_sts | evt_set;
		nxt_blk_irq = |(nxt_evt_sts & nxt_evt_msk);
	end

	////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cfg_ff <= CFG_RST; // RULE1 RULE8
			active_ff <= 1'b0;
			pre_ff <= 9'h000;
			step_ff <= 8'h00;
			asrt_ff <= 1'b0;
			pin_ff <= '{1'b0, 1'b0};
			evt_sts_ff <= EVT_RST;
			evt_msk_ff <= EVT_RST;
			blk_irq_ff <= 1'b0;
			awr_ff <= 1'b0;
			bv_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			arr_ff <= 1'b0;
			rv_ff <= 1'b0;
			rresp_ff <= RESP_OKAY;
			rdata_ff <= 32'h0000_0000;
		end else begin
			cfg_ff <= nxt_cfg;
			active_ff <= nxt_active;
			pre_ff <= nxt_pre;
			step_ff <= nxt_step;
			asrt_ff <= nxt_asrt;
			pin_ff <= nxt_pin;
			evt_sts_ff <= nxt_evt_sts;
			evt_msk_ff <= nxt_evt_msk;
			blk_irq_ff <= nxt_blk_irq;
			awr_ff <= nxt_awr;
			bv_ff <= nxt_bv;
			bresp_ff <= nxt_bresp;
			arr_ff <= nxt_arr;
			rv_ff <= nxt_rv;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
		end
	end

	// outputs straight from flops
	assign irq_pin_o = pin_ff.level;
	assign irq_pin_oe_o = pin_ff.oe;
	assign blk_irq_o = blk_irq_ff;
	assign s_axi_awready = awr_ff;
	assign s_axi_wready = awr_ff;
	assign s_axi_bvalid = bv_ff;
	assign s_axi_bresp = bresp_ff;
	assign s_axi_arready = arr_ff;
	assign s_axi_rvalid = rv_ff;
	assign s_axi_rresp = rresp_ff;
	assign s_axi_rdata = rdata_ff;

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	chk_enable_gates_pin: assert property ( // RULE8
		!cfg_ff.en |=> !asrt_ff)
		else $error("pin asserted while output disabled");
	chk_open_drain_low: assert property ( // RULE12
		!$past(cfg_ff.btype) |-> !irq_pin_o && irq_pin_oe_o == asrt_ff)
		else $error("open-drain pin drive wrong");
	chk_push_pull_pol: assert property ( // RULE11
		$past(cfg_ff.btype) |->
		irq_pin_oe_o && irq_pin_o == ~(asrt_ff ^ $past(cfg_ff.pol)))
		else $error("push-pull level does not follow polarity");
	chk_wake_no_wait: assert property ( // RULE4
		wake_event_request_i && cfg_ff.en |=> asrt_ff)
		else $error("wake request was held off");
	chk_holdoff_blocks: assert property ( // RULE6
		active_ff && !wake_event_request_i |=> !asrt_ff)
		else $error("request passed during hold-off");
	chk_zero_stops: assert property ( // RULE2
		zero_wr |=> !active_ff && step_ff == 8'h00)
		else $error("zero interval did not stop hold-off");
	chk_restart_clears: assert property ( // RULE5
		restart_wr && !zero_wr |=> active_ff && step_ff == 8'h00
		&& pre_ff == 9'h000)
		else $error("restart did not clear the counter");
	chk_master_read: assert property ( // RULE7
		rd_go && s_axi_araddr == CFG_OFFS |=>
		s_axi_rdata[MASTER_BIT] == $past(master))
		else $error("master bit does not show request line");
	chk_fall_starts: assert property ( // RULE10
		$fell(asrt_ff) && $past(cfg_ff.interval) != 8'h00
		&& !$past(zero_wr) |-> active_ff)
		else $error("de-assertion did not start hold-off");

	cov_holdoff_expire: cover property (expire);
	cov_restart_running: cover property (restart_wr && active_ff);
	cov_wake_in_holdoff: cover property (
		active_ff && wake_event_request_i ##1 asrt_ff);
endmodule : irqcfg_top
`default_nettype wire

// ===== bench/irqcfg_host.sv
// irqcfg_host: host cpu interrupt input, line held up by a pull-up
// assumes pin level and enable come straight from the block
`timescale 1ns/10ps
`default_nettype none
module irqcfg_host (
	// pin from the block
	input wire logic pin_i,
	input wire logic pin_oe_i,
	// level the host sees
	output logic line_o
);
	// released line floats high through the pull-up
	assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule : irqcfg_host
`default_nettype wire

// ===== bench/irq_output_config_deassert_test.sv
// irq_output_config_deassert_test: self-checking bench, irq pin config
// assumes irqcfg_top and irqcfg_host are compiled beforehand
`timescale 1ns/10ps
`default_nettype none
module irq_output_config_deassert_test;
	import irqcfg_pkg::*;
	////////////////////////////////////////
	// bench signals, named as the ports
	logic sys_clk_i, rst_i, wake_event_request_i, line;
	logic [7:0] src_req_i, s_axi_awaddr, s_axi_araddr;
	logic irq_pin_o, irq_pin_oe_o, blk_irq_o;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	// counters and model state
	int n_mismatch = 0, n_checks = 0, m_en, m_pol, m_typ, i;
	irqcfg_top irqcfg_top_inst (.sys_clk_i, .rst_i, .src_req_i,
		.wake_event_request_i, .irq_pin_o, .irq_pin_oe_o, .blk_irq_o,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	irqcfg_host irqcfg_host_inst (.pin_i(irq_pin_o),
		.pin_oe_i(irq_pin_oe_o), .line_o(line));
	////////////////////////////////////////
	// clock, 20 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	// verdict and end of run
	task finish_test;
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask : cyc
	// axi write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// wait for the answer; only the hang guard ends a stuck wait
		do begin
			@(posedge sys_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			r = s_axi_bresp;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		// let an edge pass before the next request
		@(posedge sys_clk_i);
	endtask : wr
	// axi read into d and r
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		// wait for the answer; only the hang guard ends a stuck wait
		do begin
			@(posedge sys_clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		// let an edge pass before the next request
		@(posedge sys_clk_i);
	endtask : rd
	////////////////////////////////////////
	// model: config word and expected line
	function automatic logic [31:0] cw(logic [7:0] v, logic a, logic m,
		logic e, logic p, logic t);
		return {v, 10'h0, a, m, 3'h0, e, 3'h0, p, 3'h0, t};
	endfunction : cw
	function automatic logic [31:0] el(int a);
		int q;
		q = a & m_en;
		return (m_typ & m_pol) != 0 ? 32'(q) : 32'(!q);
	endfunction : el
	// write config, restart bit optional
	task automatic cfg(input logic [7:0] v, input int e, p, t, rs);
		m_en = e;
		m_pol = p;
		m_typ = t;
		wr(CFG_OFFS, cw(v, 0, 0, 1'(e), 1'(p), 1'(t)) | 32'(rs << 14));
		cyc(3);
	endtask : cfg
	////////////////////////////////////////
	// hang guard
	initial begin
		cyc(20000);
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial begin
		{src_req_i, wake_event_request_i, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		rst_i = 1'b1;
		{m_en, m_pol, m_typ} = '0;
		void'($urandom(32'hdcbc));
		cyc(16);
		rst_i <= 1'b0;
		cyc(1);
		// reset values, idle line, unmapped place
		rd(CFG_OFFS);
		chk(d, 32'h0);
		chk(32'(line), el(0));
		rd(8'h70);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(8'h70, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		cfg(8'hff, 0, 0, 0, 0);
		rd(CFG_OFFS);
		chk(d, cw(8'hff, 0, 0, 0, 0, 0));
		// every polarity and buffer type
		src_req_i <= 8'($urandom_range(255, 1));
		for (i = 0; i < 4; i++) begin
			cfg(8'h00, 1, i / 2, i % 2, 0);
			chk(32'(line), el(1));
		end
		rd(CFG_OFFS);
		chk(d, cw(0, 0, 1, 1, 1, 1));
		cfg(8'h00, 0, 1, 1, 0);
		chk(32'(line), el(1));
		rd(CFG_OFFS);
		chk(d, cw(0, 0, 1, 0, 1, 1));
		// hold-off, wake bypass, zero release
		cfg(8'h01, 1, 1, 1, 0);
		rd(EVT_STS_OFFS);
		chk(d, 32'h2);
		wr(EVT_MSK_OFFS, 32'h1);
		chk(32'(r), 32'(RESP_OKAY));
		src_req_i <= 8'h00;
		cyc(3);
		rd(CFG_OFFS);
		chk(d, cw(1, 1, 0, 1, 1, 1));
		src_req_i <= 8'($urandom_range(255, 1));
		cyc(300);
		chk(32'(line), el(0));
		wake_event_request_i <= 1'b1;
		cyc(3);
		chk(32'(line), el(1));
		chk(32'(blk_irq_o), 32'h0);
		wake_event_request_i <= 1'b0;
		cyc(3);
		chk(32'(line), el(0));
		cfg(8'h00, 1, 1, 1, 0);
		chk(32'(line), el(1));
		// expiry after one step, event flags
		cfg(8'h01, 1, 1, 1, 0);
		src_req_i <= 8'h00;
		cyc(3);
		src_req_i <= 8'($urandom_range(255, 1));
		cyc(440);
		chk(32'(line), el(0));
		cyc(120);
		chk(32'(line), el(1));
		chk(32'(blk_irq_o), 32'h1);
		rd(EVT_STS_OFFS);
		chk(d, 32'h3);
		cyc(2);
		chk(32'(blk_irq_o), 32'h0);
		// restart twice under a longer interval
		src_req_i <= 8'h00;
		cfg(8'h02, 1, 1, 1, 1);
		cyc(300);
		cfg(8'h02, 1, 1, 1, 1);
		rd(CFG_OFFS);
		chk(d, cw(2, 1, 0, 1, 1, 1));
		src_req_i <= 8'($urandom_range(255, 1));
		cyc(880);
		chk(32'(line), el(0));
		cyc(150);
		chk(32'(line), el(1));
		// lane 0 only: interval byte and enable must stay as they were
		s_axi_wstrb <= 4'h1;
		wr(CFG_OFFS, 32'hff00_0000);
		s_axi_wstrb <= 4'hf;
		rd(CFG_OFFS);
		chk(d, cw(2, 0, 1, 1, 0, 0));
		finish_test();
	end
endmodule : irq_output_config_deassert_test
`default_nettype wire
